// file: src/wrtc_regs.svh
// register indices, field positions, reset values and timing counts of the
// wide time counter; assumes word-wide AHB-Lite access, byte address = 4*idx
//
// Contract
// - 32-bit counter runs continuously, wakes device
// - counter ticks from 1.024kHz or 1Hz input
// - match flag/event on tick after equality
// - wrap flag/event and zero on tick after top
// - events divided by 3/2/1 for top 0/1/else
// - no match when match exceeds top
// - enable reaches counter half a tick later
// - counter runs only when enabled, top nonzero
// - readback request bit cleared when copy done
// - pending flag during control or counter transfer
// - bits 3:2 enable match request, level
// - bits 1:0 enable wrap request, level
// - flags cleared by vector or write one
// - top writable only disabled and not pending
// - readback value ready eight cycles later
// - counter writes ignored while pending, 12 cycles
`ifndef WRTC_REGS_SVH
`define WRTC_REGS_SVH

// ==========================================================================
// register indices
`define WRTC_IDX_CTRL 8'h00
`define WRTC_IDX_SYNC 8'h01
`define WRTC_IDX_ILVL 8'h02
`define WRTC_IDX_FLAGS 8'h03
`define WRTC_IDX_CNT0 8'h04
`define WRTC_IDX_CNT3 8'h07
`define WRTC_IDX_TOP0 8'h08
`define WRTC_IDX_TOP3 8'h0B
`define WRTC_IDX_MATCH0 8'h0C
`define WRTC_IDX_MATCH3 8'h0F
`define WRTC_IDX_ISTAT 8'h10
`define WRTC_IDX_IMASK 8'h11

// ==========================================================================
// field positions
`define WRTC_CTRL_ENABLE_BIT 0
`define WRTC_SYNC_PEND_BIT 0
`define WRTC_SYNC_RDREQ_BIT 4
`define WRTC_WRAP_LVL_LSB 0
`define WRTC_MATCH_LVL_LSB 2
`define WRTC_FLAG_WRAP_BIT 0
`define WRTC_FLAG_MATCH_BIT 1

// ==========================================================================
// reset values
`define WRTC_RST_BYTE 8'h00
`define WRTC_RST_WORD 32'h0000_0000

// ==========================================================================
// timing counts in hclk cycles and counter ticks
`define WRTC_RDBK_CYC 4'h8
`define WRTC_CNT_WR_CYC 4'hC
`define WRTC_BLANK_TICKS 2'h2

`endif

// file: src/wrtc_pkg.sv
// types shared by the wide time counter core
// assumes the register header is included by the users of these types
package wrtc_pkg;

  // ========================================================================
  // captured bus address phase
  typedef struct packed {
    logic [7:0] idx;
    logic wr;
    logic rd;
  } wrtc_req_t;

  // one bit per counter event
  typedef struct packed {
    logic match;
    logic wrap;
  } wrtc_pair_t;

  // ========================================================================
  // counter write transfer state
  typedef enum logic [1:0] {
    WRTC_CW_IDLE = 2'b00,
    WRTC_CW_WAIT = 2'b01,
    WRTC_CW_BLANK = 2'b10
  } wrtc_cw_state_t;

endpackage

// file: src/wrtc_core.sv
// wide time counter core with AHB-Lite register slave and interrupts
// assumes hclk well above the counter clock; rtc_clk_in is asynchronous
`timescale 1ns/1ps
`include "wrtc_regs.svh"

module wrtc_core #(
  parameter int CNT_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rtc_clk_in,
  input wire logic match_vector_ack,
  input wire logic wrap_vector_ack,
  output logic match_irq_req,
  output logic wrap_irq_req,
  output logic [1:0] match_irq_level,
  output logic [1:0] wrap_irq_level,
  output logic match_event,
  output logic wrap_event,
  output logic wake_req,
  output logic irq
);

  // ========================================================================
  // elaboration check
  generate
    if (CNT_W != 32) begin : g_bad_width
      $error("wrtc_core serves a 32-bit counter only");
    end
  endgenerate

  // ========================================================================
  // bus address and data phases
  wrtc_pkg::wrtc_req_t req_d;
  wrtc_pkg::wrtc_req_t req_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;

  wire addr_phase = hsel && htrans[1] && hready;
  wire [7:0] a_idx = haddr[9:2];
  wire a_mapped = (haddr[31:10] == 22'h00_0000);
  wire a_rd = addr_phase && !hwrite && a_mapped;
  wire [7:0] wdat = hwdata[7:0];

  always_comb begin
    req_d.idx = a_idx;
    req_d.wr = addr_phase && hwrite && a_mapped;
    req_d.rd = a_rd;
  end

  wire wr_ctrl = req_q.wr && (req_q.idx == `WRTC_IDX_CTRL);
  wire wr_sync = req_q.wr && (req_q.idx == `WRTC_IDX_SYNC);
  wire wr_ilvl = req_q.wr && (req_q.idx == `WRTC_IDX_ILVL);
  wire wr_flags = req_q.wr && (req_q.idx == `WRTC_IDX_FLAGS);
  wire wr_imask = req_q.wr && (req_q.idx == `WRTC_IDX_IMASK);
  wire wr_cnt = req_q.wr && (req_q.idx >= `WRTC_IDX_CNT0) &&
                (req_q.idx <= `WRTC_IDX_CNT3);
  wire wr_top = req_q.wr && (req_q.idx >= `WRTC_IDX_TOP0) &&
                (req_q.idx <= `WRTC_IDX_TOP3);
  wire wr_match = req_q.wr && (req_q.idx >= `WRTC_IDX_MATCH0) &&
                  (req_q.idx <= `WRTC_IDX_MATCH3);
  wire [1:0] wr_lane = req_q.idx[1:0];
  wire rd_istat = a_rd && (a_idx == `WRTC_IDX_ISTAT);

  // ========================================================================
  // counter clock input: two flops, then an edge detector
  logic rclk_s1_q;
  logic rclk_s2_q;
  logic rclk_s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rclk_s1_q <= 1'b0;
      rclk_s2_q <= 1'b0;
      rclk_s3_q <= 1'b0;
    end else begin
      rclk_s1_q <= rtc_clk_in;
      rclk_s2_q <= rclk_s1_q;
      rclk_s3_q <= rclk_s2_q;
    end
  end

  // tick on each rising edge of the 1.024kHz or 1Hz input
  wire tick = rclk_s2_q && !rclk_s3_q;
  // any edge is half a counter clock
  wire half_edge = rclk_s2_q ^ rclk_s3_q;

  // ========================================================================
  // software registers
  logic ctrl_en_q;
  logic ctrl_busy_q;
  logic en_eff_q;
  logic [1:0] match_lvl_q;
  logic [1:0] wrap_lvl_q;
  logic [31:0] top_q;
  logic [31:0] match_q;
  logic [31:0] stage_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_rd_q;
  logic [1:0] imask_q;

  wrtc_pkg::wrtc_cw_state_t cw_q;
  logic [3:0] cw_cnt_q;
  logic [1:0] blank_q;
  logic rdbk_q;
  logic [3:0] rdbk_cnt_q;

  wire cnt_busy = (cw_q == wrtc_pkg::WRTC_CW_WAIT);
  wire pend = ctrl_busy_q || cnt_busy;
  wire top_ok = !ctrl_en_q && !en_eff_q && !pend;
  wire cnt_ok = !pend;
  wire cnt_launch = wr_cnt && cnt_ok && (wr_lane == 2'h3);
  wire rdbk_start = wr_sync && wdat[`WRTC_SYNC_RDREQ_BIT] && !rdbk_q;

  // control write crosses on the next half counter clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_q <= 1'b0;
      ctrl_busy_q <= 1'b0;
      en_eff_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_q <= wdat[`WRTC_CTRL_ENABLE_BIT];
        ctrl_busy_q <= 1'b1;
      end else if (ctrl_busy_q && half_edge) begin
        en_eff_q <= ctrl_en_q;
        ctrl_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_lvl_q <= 2'h0;
      wrap_lvl_q <= 2'h0;
      imask_q <= 2'h0;
    end else begin
      if (wr_ilvl) begin
        match_lvl_q <= wdat[`WRTC_MATCH_LVL_LSB +: 2];
        wrap_lvl_q <= wdat[`WRTC_WRAP_LVL_LSB +: 2];
      end
      if (wr_imask) begin
        imask_q <= wdat[1:0];
      end
    end
  end

  // byte-wide writes to top, match and counter staging
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      top_q <= `WRTC_RST_WORD;
      match_q <= `WRTC_RST_WORD;
      stage_q <= `WRTC_RST_WORD;
    end else begin
      if (wr_top && top_ok) begin
        top_q[wr_lane*8 +: 8] <= wdat;
      end
      if (wr_match) begin
        match_q[wr_lane*8 +: 8] <= wdat;
      end
      if (wr_cnt && cnt_ok) begin
        stage_q[wr_lane*8 +: 8] <= wdat;
      end
    end
  end

  // ========================================================================
  // counter write transfer: apply, then blank flags for two ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cw_q <= wrtc_pkg::WRTC_CW_IDLE;
      cw_cnt_q <= 4'h0;
      blank_q <= 2'h0;
    end else begin
      case (cw_q)
        wrtc_pkg::WRTC_CW_IDLE: begin
          if (cnt_launch) begin
            cw_q <= wrtc_pkg::WRTC_CW_WAIT;
            cw_cnt_q <= `WRTC_CNT_WR_CYC;
          end
        end
        wrtc_pkg::WRTC_CW_WAIT: begin
          if (cw_cnt_q == 4'h1) begin
            cw_q <= wrtc_pkg::WRTC_CW_BLANK;
            blank_q <= `WRTC_BLANK_TICKS;
          end
          cw_cnt_q <= cw_cnt_q - 4'h1;
        end
        wrtc_pkg::WRTC_CW_BLANK: begin
          if (blank_q == 2'h0) begin
            cw_q <= wrtc_pkg::WRTC_CW_IDLE;
          end else if (tick) begin
            blank_q <= blank_q - 2'h1;
          end
        end
        default: begin
          cw_q <= wrtc_pkg::WRTC_CW_IDLE;
        end
      endcase
    end
  end

  wire cnt_apply = cnt_busy && (cw_cnt_q == 4'h1);
  wire blanked = (cw_q != wrtc_pkg::WRTC_CW_IDLE);

  // ========================================================================
  // the counter
  wire run = en_eff_q && (top_q != 32'h0000_0000);
  wire at_top = (cnt_q == top_q);
  wire step = tick && run;
  wire hit_wrap = step && at_top && !blanked;
  wire hit_match = step && (cnt_q == match_q) && (match_q <= top_q) &&
                   !blanked;

  // keeps counting whenever enabled with top nonzero, independent of sleep state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= `WRTC_RST_WORD;
    end else if (cnt_apply) begin
      cnt_q <= stage_q;
    end else if (step) begin
      cnt_q <= at_top ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
    end
  end

  // ========================================================================
  // counter readback into the register side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdbk_q <= 1'b0;
      rdbk_cnt_q <= 4'h0;
      cnt_rd_q <= `WRTC_RST_WORD;
    end else if (rdbk_start) begin
      rdbk_q <= 1'b1;
      rdbk_cnt_q <= `WRTC_RDBK_CYC;
    end else if (rdbk_q) begin
      rdbk_cnt_q <= rdbk_cnt_q - 4'h1;
      if (rdbk_cnt_q == 4'h1) begin
        cnt_rd_q <= cnt_q;
        rdbk_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // event division for small top values
  logic [1:0] ev_cnt_q [2];
  logic [1:0] ev_fire_q;
  wire [1:0] ev_mod = (top_q == 32'h0000_0000) ? 2'h3 :
                      (top_q == 32'h0000_0001) ? 2'h2 : 2'h1;
  wire [1:0] ev_hit = {hit_match, hit_wrap};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_ev
      wire [1:0] nxt = ev_cnt_q[i] + 2'h1;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ev_cnt_q[i] <= 2'h0;
          ev_fire_q[i] <= 1'b0;
        end else begin
          ev_fire_q[i] <= ev_hit[i] && (nxt >= ev_mod);
          if (ev_hit[i]) begin
            ev_cnt_q[i] <= (nxt >= ev_mod) ? 2'h0 : nxt;
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // flags, sticky status and interrupt outputs
  wrtc_pkg::wrtc_pair_t flag_q;
  wrtc_pkg::wrtc_pair_t flag_d;
  logic [1:0] istat_q;
  logic [1:0] istat_d;
  logic match_irq_q;
  logic wrap_irq_q;
  logic wake_q;
  logic irq_q;

  // a new event wins over a clear in the same cycle
  always_comb begin
    flag_d.match = hit_match || (flag_q.match && !match_vector_ack &&
                   !(wr_flags && wdat[`WRTC_FLAG_MATCH_BIT]));
    flag_d.wrap = hit_wrap || (flag_q.wrap && !wrap_vector_ack &&
                  !(wr_flags && wdat[`WRTC_FLAG_WRAP_BIT]));
    istat_d = ev_hit | (rd_istat ? 2'h0 : istat_q);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= '0;
      istat_q <= 2'h0;
      match_irq_q <= 1'b0;
      wrap_irq_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      istat_q <= istat_d;
      match_irq_q <= flag_d.match && (match_lvl_q != 2'h0);
      wrap_irq_q <= flag_d.wrap && (wrap_lvl_q != 2'h0);
      wake_q <= hit_match || hit_wrap;
      irq_q <= |(istat_d & imask_q);
    end
  end

  // ========================================================================
  // read mux; reserved bits read as zero
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (a_idx >= `WRTC_IDX_CNT0 && a_idx <= `WRTC_IDX_CNT3) begin
      rd_byte = cnt_rd_q[a_idx[1:0]*8 +: 8];
    end else if (a_idx >= `WRTC_IDX_TOP0 && a_idx <= `WRTC_IDX_TOP3) begin
      rd_byte = top_q[a_idx[1:0]*8 +: 8];
    end else if (a_idx >= `WRTC_IDX_MATCH0 &&
                 a_idx <= `WRTC_IDX_MATCH3) begin
      rd_byte = match_q[a_idx[1:0]*8 +: 8];
    end else begin
      case (a_idx)
        `WRTC_IDX_CTRL: rd_byte = {7'h00, ctrl_en_q};
        `WRTC_IDX_SYNC: rd_byte = {3'h0, rdbk_q, 3'h0, pend};
        `WRTC_IDX_ILVL: rd_byte = {4'h0, match_lvl_q, wrap_lvl_q};
        `WRTC_IDX_FLAGS: rd_byte = {6'h00, flag_q.match, flag_q.wrap};
        `WRTC_IDX_ISTAT: rd_byte = {6'h00, istat_q};
        `WRTC_IDX_IMASK: rd_byte = {6'h00, imask_q};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      hrdata_q <= `WRTC_RST_WORD;
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= 1'b1;
      if (hready) begin
        req_q <= req_d;
      end
      if (a_rd) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ========================================================================
  // outputs
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign match_irq_req = match_irq_q;
  assign wrap_irq_req = wrap_irq_q;
  assign match_irq_level = match_lvl_q;
  assign wrap_irq_level = wrap_lvl_q;
  assign match_event = ev_fire_q[1];
  assign wrap_event = ev_fire_q[0];
  assign wake_req = wake_q;
  assign irq = irq_q;

endmodule

// file: bench/wrtc_monitor.sv
// concurrent checks on the ports of the wide time counter core
// assumes a single clock domain, hclk, with hresetn active low
`timescale 1ns/1ps

module wrtc_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic match_vector_ack,
  input wire logic wrap_vector_ack,
  input wire logic match_irq_req,
  input wire logic wrap_irq_req,
  input wire logic [1:0] match_irq_level,
  input wire logic [1:0] wrap_irq_level,
  input wire logic match_event,
  input wire logic wrap_event,
  input wire logic wake_req,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ========================================================================
  // requests, events and wake
  property p_mreq;
    match_irq_req |-> (match_irq_level != 2'h0 ||
                       $past(match_irq_level) != 2'h0);
  endproperty
  a_mreq: assert property (p_mreq) else $error("match req, level 0");
  property p_wreq;
    wrap_irq_req |-> (wrap_irq_level != 2'h0 ||
                      $past(wrap_irq_level) != 2'h0);
  endproperty
  a_wreq: assert property (p_wreq) else $error("wrap req, level 0");
  property p_mev;
    match_event |-> wake_req;
  endproperty
  a_mev: assert property (p_mev) else $error("match event w/o hit");
  property p_wev;
    wrap_event |-> wake_req;
  endproperty
  a_wev: assert property (p_wev) else $error("wrap event w/o hit");
  property p_wev_pulse;
    wrap_event |=> !wrap_event;
  endproperty
  a_wev_pulse: assert property (p_wev_pulse) else $error("long event");
  property p_wake;
    wake_req |=> !wake_req [*3];
  endproperty
  a_wake: assert property (p_wake) else $error("wake not a pulse");
  property p_mack;
    match_vector_ack |=> (!match_irq_req || wake_req);
  endproperty
  a_mack: assert property (p_mack) else $error("match ack no clear");
  property p_wack;
    wrap_vector_ack |=> (!wrap_irq_req || wake_req);
  endproperty
  a_wack: assert property (p_wack) else $error("wrap ack no clear");

  c_wev: cover property (wrap_event);
  c_mev: cover property (match_event);
  c_irq: cover property ($rose(irq));
endmodule

bind wrtc_core wrtc_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .match_vector_ack(match_vector_ack), .wrap_vector_ack(wrap_vector_ack),
  .match_irq_req(match_irq_req), .wrap_irq_req(wrap_irq_req),
  .match_irq_level(match_irq_level), .wrap_irq_level(wrap_irq_level),
  .match_event(match_event), .wrap_event(wrap_event),
  .wake_req(wake_req), .irq(irq));

// file: bench/tb_top.sv
// self-checking bench of the wide time counter core over AHB-Lite
// assumes zero wait state slave; counter clock driven only in bursts
`timescale 1ns/1ps

module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rtc_clk_in = 1'b0;
  logic mack = 1'b0;
  logic wack = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, match_irq_req, wrap_irq_req;
  logic [1:0] match_irq_level, wrap_irq_level;
  logic match_event, wrap_event, wake_req, irq;
  logic [15:0] seed = 16'h9477;
  int n_errors = 0;
  int num_checks = 0;
  int n_wev = 0;

  wrtc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rtc_clk_in(rtc_clk_in),
    .match_vector_ack(mack), .wrap_vector_ack(wack),
    .match_irq_req(match_irq_req), .wrap_irq_req(wrap_irq_req),
    .match_irq_level(match_irq_level), .wrap_irq_level(wrap_irq_level),
    .match_event(match_event), .wrap_event(wrap_event),
    .wake_req(wake_req), .irq(irq));

  always #5 hclk = ~hclk;
  always @(posedge hclk) if (wrap_event === 1'b1) n_wev <= n_wev + 1;

  // ========================================================================
  // helpers
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // match flag only while match lies within top; wrap always
  function logic [31:0] exp_flags(input logic [31:0] top, input logic [31:0] m);
    return {30'h0, m <= top, 1'b1};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task rd(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(x, e);
  endtask
  // byte 3 last: it launches the transfer
  task wr32(input logic [7:0] idx, input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(idx + 8'(i), {24'h0, v[8*i +: 8]});
  endtask
  task tick(input int n);
    repeat (n) begin
      rtc_clk_in <= 1'b1;
      repeat (10) @(posedge hclk);
      rtc_clk_in <= 1'b0;
      repeat (10) @(posedge hclk);
    end
  endtask
  task pulse_ack(input logic m);
    if (m) mack <= 1'b1; else wack <= 1'b1;
    @(posedge hclk);
    mack <= 1'b0;
    wack <= 1'b0;
    @(posedge hclk);
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    conclude();
  end

  // ========================================================================
  // main sequence
  initial begin
    logic [7:0] rst_idx [8];
    logic [31:0] v;
    rst_idx = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h0C, 8'h10, 8'h11};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rst_idx[i]) rd(rst_idx[i], 32'h0);
    chk({29'h0, irq, match_irq_req, wrap_irq_req}, 32'h0);
    repeat (3) begin
      seed = lfsr(seed);
      wr(8'h02, {28'h0, seed[3:0]});
      rd(8'h02, {28'h0, seed[3:0]});
      chk({28'h0, match_irq_level, wrap_irq_level}, {28'h0, seed[3:0]});
    end
    rd(8'h20, 32'h0);
    seed = lfsr(seed);
    v[15:0] = seed;
    seed = lfsr(seed);
    v[31:16] = seed;
    wr32(8'h04, v);
    rd(8'h01, 32'h1);
    wr(8'h07, {24'h0, ~v[31:24]});
    repeat (12) @(posedge hclk);
    rd(8'h01, 32'h0);
    wr(8'h01, 32'h10);
    rd(8'h01, 32'h10);
    repeat (8) @(posedge hclk);
    rd(8'h01, 32'h0);
    for (int i = 0; i < 4; i++) rd(8'h04 + 8'(i), {24'h0, v[8*i +: 8]});
    // enabled with top zero must not count; top locked while enabled
    wr(8'h00, 32'h1);
    rd(8'h01, 32'h1);
    wr(8'h08, 32'h55);
    tick(3);
    wr(8'h01, 32'h10);
    repeat (8) @(posedge hclk);
    rd(8'h08, 32'h0);
    rd(8'h04, {24'h0, v[7:0]});
    // run with top 3, match 1
    wr(8'h00, 32'h0);
    tick(1);
    wr32(8'h04, 32'h0);
    repeat (12) @(posedge hclk);
    wr32(8'h08, 32'h3);
    wr32(8'h0C, 32'h1);
    wr(8'h02, 32'h5);
    wr(8'h11, 32'h3);
    wr(8'h00, 32'h1);
    tick(12);
    rd(8'h03, exp_flags(32'h3, 32'h1));
    chk({29'h0, irq, match_irq_req, wrap_irq_req}, 32'h7);
    chk({31'h0, n_wev >= 2}, 32'h1);
    rd(8'h10, 32'h3);
    rd(8'h10, 32'h0);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h03, 32'h1);
    rd(8'h03, 32'h2);
    chk({31'h0, wrap_irq_req}, 32'h0);
    pulse_ack(1'b1);
    rd(8'h03, 32'h0);
    // match beyond top never hits
    wr(8'h00, 32'h0);
    tick(1);
    wr32(8'h0C, 32'h5);
    wr(8'h00, 32'h1);
    tick(8);
    rd(8'h03, exp_flags(32'h3, 32'h5));
    pulse_ack(1'b0);
    rd(8'h03, 32'h0);
    conclude();
  end
endmodule
